// ===== perf_alloc_pkg.sv
// constants, field layout and carrier types for the bus queue allocation event filter
package perf_alloc_pkg;

	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned MASK_W = 16;
	localparam int unsigned CNT_W  = 32;
	localparam int unsigned RT_W   = 5;
	localparam int unsigned MEM_W  = 5;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MATCH  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SECTOR = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CHUNK  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_RETRY  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_BYTES  = 8'h1c;

	// ------------------------------------------------------------------
	// event mask field positions
	// ------------------------------------------------------------------
	localparam int unsigned RT_LSB       = 0;
	localparam int unsigned READ_BIT     = 5;
	localparam int unsigned WRITE_BIT    = 6;
	localparam int unsigned MEM_LSB      = 7;
	localparam int unsigned OWN_BIT      = 13;
	localparam int unsigned OTHER_BIT    = 14;
	localparam int unsigned PREFETCH_BIT = 15;

	// memory type one-hot positions inside the memory field
	localparam int unsigned UNCACHEABLE_TYPE_SELECT     = 0;
	localparam int unsigned WRITE_COMBINING_TYPE_SELECT = 1;
	localparam int unsigned WRITE_THROUGH_TYPE_SELECT   = 2;
	localparam int unsigned WRITE_PROTECTED_TYPE_SELECT = 3;
	localparam int unsigned WRITE_BACK_TYPE_SELECT      = 4;

	// ------------------------------------------------------------------
	// control / status bits and reset values
	// ------------------------------------------------------------------
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_CLR_BIT  = 1;
	localparam int unsigned STAT_SEEN_BIT = 0;
	localparam int unsigned STAT_EN_BIT   = 1;

	localparam logic [RT_W-1:0]   RT_DEFAULT   = 5'h01;
	localparam logic [MASK_W-1:0] MASK_RESET   = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_RESET    = 32'h0000_0000;
	localparam logic [CNT_W-1:0]  CNT_ONE      = 32'h0000_0001;
	localparam logic [CNT_W-1:0]  SECTOR_BYTES = 32'h0000_0040;
	localparam logic [CNT_W-1:0]  CHUNK_BYTES  = 32'h0000_0008;

	// ------------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [RT_W-1:0]  req_type;
		logic             is_read;
		logic             is_write;
		logic [MEM_W-1:0] mem_type;
		logic             own_agent;
		logic             is_prefetch;
		logic             is_retry;
		logic             is_sector;
	} alloc_txn_t;

	typedef struct packed {
		logic req_term;
		logic rw_term;
		logic mem_term;
		logic src_term;
		logic pf_block;
		logic hit;
	} match_terms_t;

endpackage : perf_alloc_pkg

// ===== alloc_match_eval.sv
// combinational match expression for one allocated queue entry
`timescale 1ns/100ps
module alloc_match_eval (
	input  wire logic [perf_alloc_pkg::MASK_W-1:0] mask_in,
	input  wire perf_alloc_pkg::alloc_txn_t        txn_in,
	output perf_alloc_pkg::match_terms_t           terms_out
);

	logic [perf_alloc_pkg::RT_W-1:0]  mask_rt;
	logic [perf_alloc_pkg::MEM_W-1:0] mem_sel;

	assign mask_rt = mask_in[perf_alloc_pkg::RT_LSB +: perf_alloc_pkg::RT_W];

	// ------------------------------------------------------------------
	// memory type field, one select bit per type
	// ------------------------------------------------------------------
	for (genvar i = 0; i < perf_alloc_pkg::MEM_W; i++) begin : g_mem
		assign mem_sel[i] = mask_in[perf_alloc_pkg::MEM_LSB + i] & txn_in.mem_type[i]; // [RULE9]
	end

	always_comb begin
		// the default code selects no request type at all
		terms_out.req_term = (mask_rt != perf_alloc_pkg::RT_DEFAULT) &&
			(txn_in.req_type == mask_rt); // [RULE8]
		terms_out.rw_term  = (mask_in[perf_alloc_pkg::READ_BIT] & txn_in.is_read) |
			(mask_in[perf_alloc_pkg::WRITE_BIT] & txn_in.is_write); // [RULE6]
		terms_out.mem_term = |mem_sel; // [RULE4]
		// own agent counts only its stores; foreign agents need their own bit
		terms_out.src_term = (mask_in[perf_alloc_pkg::OWN_BIT] & txn_in.own_agent & txn_in.is_write) |
			(mask_in[perf_alloc_pkg::OTHER_BIT] & ~txn_in.own_agent); // [RULE10] [RULE11]
		// prefetch qualifier acts on reads only
		terms_out.pf_block = txn_in.is_prefetch & txn_in.is_read &
			~mask_in[perf_alloc_pkg::PREFETCH_BIT]; // [RULE12]
		terms_out.hit = ((terms_out.req_term | terms_out.rw_term) | terms_out.mem_term) &
			terms_out.src_term & ~terms_out.pf_block; // [RULE7] [RULE4]
	end

endmodule : alloc_match_eval

// ===== bus_queue_alloc_event_filter.sv
// bus queue allocation event filter: mask register, match qualification and count pulse
// Functional notes
// RULE1: each allocation into the bus transaction queue that matches the mask gives one count pulse.
// RULE2: every counted entry stands for either a 64-byte sector or an 8-byte chunk.
// RULE3: a retried request is counted again on every retry allocation that matches.
// RULE4: mask fields are independent, bits 0-4 form the request-type field, and selections within a field are ORed.
// RULE5: software sets at least one bit in every field so that each field value is selected.
// RULE6: the request-type field joins bit 5 (reads) and bit 6 (writes) in one term of the expression.
// RULE7: a match is ((request type or bit 5 or bit 6) or memory type) and source agent.
// RULE8: request-type code 00001 means invalid or default and selects no request type.
// RULE9: bits 7 to 11 select uncacheable, write-combining, write-through, write-protected and write-back entries.
// RULE10: bits 13 and 14 form the source field: own stores and requests of other agents or DMA.
// RULE11: requests of other agents or DMA count only when bit 14 is set.
// RULE12: bit 15 adds prefetch requests to the count and affects reads only.
`timescale 1ns/100ps
module bus_queue_alloc_event_filter (
	input  wire logic                                clk_in,
	input  wire logic                                rst_in,
	input  wire logic                                queue_alloc_event_in,
	input  wire perf_alloc_pkg::alloc_txn_t          alloc_txn_in,
	input  wire logic [perf_alloc_pkg::ADDR_W-1:0]   reg_addr_in,
	input  wire logic [perf_alloc_pkg::DATA_W-1:0]   reg_wdata_in,
	input  wire logic                                reg_wr_in,
	input  wire logic                                reg_rd_in,
	output logic      [perf_alloc_pkg::DATA_W-1:0]   reg_rdata_out,
	output logic                                     count_pulse_out,
	output logic                                     count_sector_out
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [perf_alloc_pkg::MASK_W-1:0] event_select_control_reg_ff;
	logic [perf_alloc_pkg::MASK_W-1:0] nxt_event_select_control_reg;
	logic                              enable_ff;
	logic                              nxt_enable;
	logic                              seen_ff;
	logic                              nxt_seen;
	logic [perf_alloc_pkg::CNT_W-1:0]  match_cnt_ff;
	logic [perf_alloc_pkg::CNT_W-1:0]  nxt_match_cnt;
	logic [perf_alloc_pkg::CNT_W-1:0]  sector_cnt_ff;
	logic [perf_alloc_pkg::CNT_W-1:0]  nxt_sector_cnt;
	logic [perf_alloc_pkg::CNT_W-1:0]  chunk_cnt_ff;
	logic [perf_alloc_pkg::CNT_W-1:0]  nxt_chunk_cnt;
	logic [perf_alloc_pkg::CNT_W-1:0]  retry_cnt_ff;
	logic [perf_alloc_pkg::CNT_W-1:0]  nxt_retry_cnt;
	logic [perf_alloc_pkg::CNT_W-1:0]  byte_cnt_ff;
	logic [perf_alloc_pkg::CNT_W-1:0]  nxt_byte_cnt;
	logic [perf_alloc_pkg::DATA_W-1:0] rdata_ff;
	logic [perf_alloc_pkg::DATA_W-1:0] nxt_rdata;
	logic                              pulse_ff;
	logic                              nxt_pulse;
	logic                              sector_ff;
	logic                              nxt_sector;

	perf_alloc_pkg::match_terms_t      terms;
	logic                              hit_now;
	logic                              wr_mask;
	logic                              wr_ctrl;
	logic                              wr_status;
	logic                              clr_cnt;

	// ------------------------------------------------------------------
	// match evaluation
	// ------------------------------------------------------------------
	alloc_match_eval u_match (
		.mask_in   (event_select_control_reg_ff),
		.txn_in    (alloc_txn_in),
		.terms_out (terms)
	);

	// no dedup of retries: every allocation stands on its own
	assign hit_now   = queue_alloc_event_in & enable_ff & terms.hit; // [RULE1] [RULE3]
	assign wr_mask   = reg_wr_in && (reg_addr_in == perf_alloc_pkg::OFS_MASK);
	assign wr_ctrl   = reg_wr_in && (reg_addr_in == perf_alloc_pkg::OFS_CTRL);
	assign wr_status = reg_wr_in && (reg_addr_in == perf_alloc_pkg::OFS_STATUS);
	assign clr_cnt   = wr_ctrl & reg_wdata_in[perf_alloc_pkg::CTRL_CLR_BIT];

	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------
	always_comb begin
		nxt_event_select_control_reg = event_select_control_reg_ff;
		nxt_enable                   = enable_ff;
		if (wr_mask) begin
			nxt_event_select_control_reg = reg_wdata_in[perf_alloc_pkg::MASK_W-1:0];
		end
		if (wr_ctrl) begin
			nxt_enable = reg_wdata_in[perf_alloc_pkg::CTRL_EN_BIT];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			event_select_control_reg_ff <= perf_alloc_pkg::MASK_RESET;
			enable_ff                   <= 1'b0;
		end else begin
			event_select_control_reg_ff <= nxt_event_select_control_reg;
			enable_ff                   <= nxt_enable;
		end
	end

	// ------------------------------------------------------------------
	// count pulse and counters
	// ------------------------------------------------------------------
	// a clear in the same cycle as a hit keeps that hit, so nothing is lost
	always_comb begin
		nxt_pulse      = hit_now; // [RULE1]
		nxt_sector     = hit_now & alloc_txn_in.is_sector; // [RULE2]
		nxt_match_cnt  = clr_cnt ? perf_alloc_pkg::CNT_RESET : match_cnt_ff;
		nxt_sector_cnt = clr_cnt ? perf_alloc_pkg::CNT_RESET : sector_cnt_ff;
		nxt_chunk_cnt  = clr_cnt ? perf_alloc_pkg::CNT_RESET : chunk_cnt_ff;
		nxt_retry_cnt  = clr_cnt ? perf_alloc_pkg::CNT_RESET : retry_cnt_ff;
		nxt_byte_cnt   = clr_cnt ? perf_alloc_pkg::CNT_RESET : byte_cnt_ff;
		if (hit_now) begin
			nxt_match_cnt = nxt_match_cnt + perf_alloc_pkg::CNT_ONE; // [RULE1]
			if (alloc_txn_in.is_sector) begin
				nxt_sector_cnt = nxt_sector_cnt + perf_alloc_pkg::CNT_ONE; // [RULE2]
				nxt_byte_cnt   = nxt_byte_cnt + perf_alloc_pkg::SECTOR_BYTES; // [RULE2]
			end else begin
				nxt_chunk_cnt = nxt_chunk_cnt + perf_alloc_pkg::CNT_ONE; // [RULE2]
				nxt_byte_cnt  = nxt_byte_cnt + perf_alloc_pkg::CHUNK_BYTES; // [RULE2]
			end
			if (alloc_txn_in.is_retry) begin
				nxt_retry_cnt = nxt_retry_cnt + perf_alloc_pkg::CNT_ONE; // [RULE3]
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pulse_ff      <= 1'b0;
			sector_ff     <= 1'b0;
			match_cnt_ff  <= perf_alloc_pkg::CNT_RESET;
			sector_cnt_ff <= perf_alloc_pkg::CNT_RESET;
			chunk_cnt_ff  <= perf_alloc_pkg::CNT_RESET;
			retry_cnt_ff  <= perf_alloc_pkg::CNT_RESET;
			byte_cnt_ff   <= perf_alloc_pkg::CNT_RESET;
		end else begin
			pulse_ff      <= nxt_pulse;
			sector_ff     <= nxt_sector;
			match_cnt_ff  <= nxt_match_cnt;
			sector_cnt_ff <= nxt_sector_cnt;
			chunk_cnt_ff  <= nxt_chunk_cnt;
			retry_cnt_ff  <= nxt_retry_cnt;
			byte_cnt_ff   <= nxt_byte_cnt;
		end
	end

	// ------------------------------------------------------------------
	// sticky seen flag and read port
	// ------------------------------------------------------------------
	always_comb begin
		nxt_seen = (seen_ff & ~(wr_status & reg_wdata_in[perf_alloc_pkg::STAT_SEEN_BIT])) | hit_now;
		nxt_rdata = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				perf_alloc_pkg::OFS_MASK: begin
					nxt_rdata[perf_alloc_pkg::MASK_W-1:0] = event_select_control_reg_ff;
				end
				perf_alloc_pkg::OFS_CTRL: begin
					nxt_rdata[perf_alloc_pkg::CTRL_EN_BIT] = enable_ff;
				end
				perf_alloc_pkg::OFS_MATCH: begin
					nxt_rdata = match_cnt_ff;
				end
				perf_alloc_pkg::OFS_SECTOR: begin
					nxt_rdata = sector_cnt_ff;
				end
				perf_alloc_pkg::OFS_CHUNK: begin
					nxt_rdata = chunk_cnt_ff;
				end
				perf_alloc_pkg::OFS_RETRY: begin
					nxt_rdata = retry_cnt_ff;
				end
				perf_alloc_pkg::OFS_STATUS: begin
					nxt_rdata[perf_alloc_pkg::STAT_SEEN_BIT] = seen_ff;
					nxt_rdata[perf_alloc_pkg::STAT_EN_BIT]   = enable_ff;
				end
				perf_alloc_pkg::OFS_BYTES: begin
					nxt_rdata = byte_cnt_ff;
				end
				default: begin
					nxt_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			seen_ff  <= 1'b0;
			rdata_ff <= '0;
		end else begin
			seen_ff  <= nxt_seen;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_out    = rdata_ff;
	assign count_pulse_out  = pulse_ff;
	assign count_sector_out = sector_ff;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	property p_hit_pulses;
		@(posedge clk_in) disable iff (rst_in)
		(queue_alloc_event_in && enable_ff && terms.hit) |=> count_pulse_out;
	endproperty
	a_hit_pulses: assert property (p_hit_pulses) else $error("matching allocation gave no pulse"); // [RULE1]

	property p_pulse_has_cause;
		@(posedge clk_in) disable iff (rst_in)
		count_pulse_out |-> $past(queue_alloc_event_in) && $past(enable_ff) && $past(terms.src_term);
	endproperty
	a_pulse_has_cause: assert property (p_pulse_has_cause) else $error("pulse without qualified allocation"); // [RULE7]

	property p_unit_bytes;
		@(posedge clk_in) disable iff (rst_in)
		(hit_now && !clr_cnt) |=>
			(byte_cnt_ff == $past(byte_cnt_ff) + (count_sector_out ? perf_alloc_pkg::SECTOR_BYTES
			                                                       : perf_alloc_pkg::CHUNK_BYTES));
	endproperty
	a_unit_bytes: assert property (p_unit_bytes) else $error("byte count did not add 64 or 8"); // [RULE2]

	property p_retry_counted;
		@(posedge clk_in) disable iff (rst_in)
		(hit_now && alloc_txn_in.is_retry && !clr_cnt) |=>
			(retry_cnt_ff == $past(retry_cnt_ff) + perf_alloc_pkg::CNT_ONE) && count_pulse_out;
	endproperty
	a_retry_counted: assert property (p_retry_counted) else $error("retry allocation not counted"); // [RULE3]

	property p_default_type_silent;
		@(posedge clk_in) disable iff (rst_in)
		(queue_alloc_event_in && (event_select_control_reg_ff[11:0] == 12'h001)) |=> !count_pulse_out;
	endproperty
	a_default_type_silent: assert property (p_default_type_silent) else $error("default type alone counted"); // [RULE8]

	property p_foreign_needs_bit;
		@(posedge clk_in) disable iff (rst_in)
		(queue_alloc_event_in && !alloc_txn_in.own_agent &&
			!event_select_control_reg_ff[perf_alloc_pkg::OTHER_BIT]) |=> !count_pulse_out;
	endproperty
	a_foreign_needs_bit: assert property (p_foreign_needs_bit) else $error("foreign request counted"); // [RULE11]

	property p_prefetch_read_blocked;
		@(posedge clk_in) disable iff (rst_in)
		(queue_alloc_event_in && alloc_txn_in.is_prefetch && alloc_txn_in.is_read &&
			!event_select_control_reg_ff[perf_alloc_pkg::PREFETCH_BIT]) |=> !count_pulse_out;
	endproperty
	a_prefetch_read_blocked: assert property (p_prefetch_read_blocked) else $error("prefetch read counted"); // [RULE12]

	property p_mem_type_counts;
		@(posedge clk_in) disable iff (rst_in)
		(queue_alloc_event_in && enable_ff && terms.src_term && !terms.pf_block &&
			|(event_select_control_reg_ff[11:7] & alloc_txn_in.mem_type)) |=> count_pulse_out;
	endproperty
	a_mem_type_counts: assert property (p_mem_type_counts) else $error("memory type match lost"); // [RULE9]

	property p_read_term_counts;
		@(posedge clk_in) disable iff (rst_in)
		(queue_alloc_event_in && enable_ff && terms.src_term && !terms.pf_block && alloc_txn_in.is_read &&
			event_select_control_reg_ff[perf_alloc_pkg::READ_BIT]) |=>
			count_pulse_out;
	endproperty
	a_read_term_counts: assert property (p_read_term_counts) else $error("read qualifier lost"); // [RULE6]

	property p_own_store_counts;
		@(posedge clk_in) disable iff (rst_in)
		(queue_alloc_event_in && enable_ff && alloc_txn_in.own_agent && alloc_txn_in.is_write &&
			!alloc_txn_in.is_read && event_select_control_reg_ff[perf_alloc_pkg::OWN_BIT] &&
			event_select_control_reg_ff[perf_alloc_pkg::WRITE_BIT]) |=> count_pulse_out;
	endproperty
	a_own_store_counts: assert property (p_own_store_counts) else $error("own store not counted"); // [RULE10]

	property p_read_once;
		@(posedge clk_in) disable iff (rst_in)
		(!reg_rd_in) |=> (reg_rdata_out == '0);
	endproperty
	a_read_once: assert property (p_read_once) else $error("read data outside its cycle");

	c_sector_hit: cover property (@(posedge clk_in) disable iff (rst_in) count_pulse_out && count_sector_out);
	c_chunk_hit: cover property (@(posedge clk_in) disable iff (rst_in) count_pulse_out && !count_sector_out);
	c_retry_hit: cover property (@(posedge clk_in) disable iff (rst_in) hit_now && alloc_txn_in.is_retry);
	c_back_to_back: cover property (@(posedge clk_in) disable iff (rst_in) count_pulse_out [*3]);

endmodule : bus_queue_alloc_event_filter

// ===== alloc_source.sv
// partner model: bus transaction queue allocation source
`timescale 1ns/100ps
module alloc_source (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  slow_in,
	output logic                       queue_alloc_event_out,
	output perf_alloc_pkg::alloc_txn_t alloc_txn_out
);
	perf_alloc_pkg::alloc_txn_t txn_q[$];

	// a retried request enters the queue again as a fresh allocation
	task automatic push(input perf_alloc_pkg::alloc_txn_t t);
		txn_q.push_back(t);
		if (t.is_retry)
			txn_q.push_back(t);
	endtask : push

	function automatic int pending();
		return txn_q.size() + int'(queue_alloc_event_out);
	endfunction : pending

	// --------------------------------------------------------------
	// one allocation a cycle at most; slow mode leaves a gap after each
	// --------------------------------------------------------------
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			queue_alloc_event_out <= 1'b0;
			alloc_txn_out         <= '0;
		end else if (txn_q.size() != 0 && !(slow_in && queue_alloc_event_out)) begin
			queue_alloc_event_out <= 1'b1;
			alloc_txn_out         <= txn_q.pop_front();
		end else begin
			// attributes are not valid here: keep them moving so nothing relies on them
			queue_alloc_event_out <= 1'b0;
			alloc_txn_out         <= ~alloc_txn_out;
		end
	end
endmodule : alloc_source

// ===== testbench.sv
// self-checking testbench for the bus queue allocation event filter
`timescale 1ns/100ps
module testbench;
	logic                              clk_in;
	logic                              rst_in;
	logic                              slow_in;
	logic                              queue_alloc_event_in;
	perf_alloc_pkg::alloc_txn_t        alloc_txn_in;
	logic [perf_alloc_pkg::ADDR_W-1:0] reg_addr_in;
	logic [perf_alloc_pkg::DATA_W-1:0] reg_wdata_in;
	logic                              reg_wr_in;
	logic                              reg_rd_in;
	logic [perf_alloc_pkg::DATA_W-1:0] reg_rdata_out;
	logic                              count_pulse_out;
	logic                              count_sector_out;
	int                                failures;
	int                                cmp_count;
	logic [15:0]                       mask_sh;
	logic                              en_sh, seen_sh, hit, exp_p, exp_s;
	logic [31:0]                       n_match, n_sector, n_chunk, n_retry, n_bytes;
	// the last entry selects a value in every field
	logic [15:0]                       masks [8] = '{16'h2001, 16'h6003, 16'h4020, 16'h6040,
	                                                 16'h4080, 16'hc020, 16'h6f80, 16'hefe3};

	bus_queue_alloc_event_filter u_bus_queue_alloc_event_filter (
		.clk_in(clk_in), .rst_in(rst_in), .queue_alloc_event_in(queue_alloc_event_in),
		.alloc_txn_in(alloc_txn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.count_pulse_out(count_pulse_out), .count_sector_out(count_sector_out));

	alloc_source u_alloc_source (
		.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow_in),
		.queue_alloc_event_out(queue_alloc_event_in), .alloc_txn_out(alloc_txn_in));

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	function automatic logic exp_hit(input logic [15:0] m, input perf_alloc_pkg::alloc_txn_t t);
		logic req, rw, mem, src, pf;
		req = (m[4:0] != 5'h01) && (t.req_type == m[4:0]);
		rw  = (m[5] && t.is_read) || (m[6] && t.is_write);
		mem = |(m[11:7] & t.mem_type);
		src = (m[13] && t.own_agent && t.is_write) || (m[14] && !t.own_agent);
		pf  = t.is_prefetch && t.is_read && !m[15];
		return (req || rw || mem) && src && !pf;
	endfunction : exp_hit

	function automatic perf_alloc_pkg::alloc_txn_t mk(input int k);
		perf_alloc_pkg::alloc_txn_t t;
		t.req_type    = 5'(k >> 2);
		t.is_read     = k[0];
		t.is_write    = ~k[0];
		t.mem_type    = 5'(5'h01 << (k % 5));
		t.own_agent   = k[1];
		t.is_prefetch = k[2];
		t.is_retry    = k[3];
		t.is_sector   = k[4];
		return t;
	endfunction : mk

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_wr_in    <= 1'b1;
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in    <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge clk_in);
		reg_rd_in   <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in   <= 1'b0;
		@(posedge clk_in);
		check(name, exp, reg_rdata_out);
		@(posedge clk_in);
		check("rdata_idle", 32'h0, reg_rdata_out);
	endtask : reg_read

	task automatic check_counts();
		reg_read(perf_alloc_pkg::OFS_MATCH, n_match, "match");
		reg_read(perf_alloc_pkg::OFS_SECTOR, n_sector, "sector");
		reg_read(perf_alloc_pkg::OFS_CHUNK, n_chunk, "chunk");
		reg_read(perf_alloc_pkg::OFS_RETRY, n_retry, "retry");
		reg_read(perf_alloc_pkg::OFS_BYTES, n_bytes, "bytes");
		reg_read(perf_alloc_pkg::OFS_STATUS, {30'h0, en_sh, seen_sh}, "status");
	endtask : check_counts

	task automatic send_all_and_drain(input int mi);
		int n;
		for (int k = 0; k < 32; k++)
			u_alloc_source.push(mk(k));
		// mask and clear land while allocations are flowing
		if (mi >= 0)
			reg_write(perf_alloc_pkg::OFS_MASK, {16'h0, masks[mi]});
		if (mi == 4)
			reg_write(perf_alloc_pkg::OFS_CTRL, 32'h3);
		n = 0;
		while (u_alloc_source.pending() != 0 && n < 1000) begin
			@(posedge clk_in);
			n++;
		end
		check("drain", 32'h0, 32'(u_alloc_source.pending()));
		repeat (3) @(posedge clk_in);
		check_counts();
	endtask : send_all_and_drain

	task automatic report_and_stop();
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// --------------------------------------------------------------
	// reference model: sees the same edges the design sees
	// --------------------------------------------------------------
	always @(posedge clk_in) begin
		if (!rst_in) begin
			check("count_pulse", 32'(exp_p), 32'(count_pulse_out));
			check("count_sector", 32'(exp_s), 32'(count_sector_out));
			hit   = queue_alloc_event_in && en_sh && exp_hit(mask_sh, alloc_txn_in);
			exp_p = hit;
			exp_s = hit && alloc_txn_in.is_sector;
			if (reg_wr_in && reg_addr_in == perf_alloc_pkg::OFS_CTRL && reg_wdata_in[1])
				{n_match, n_sector, n_chunk, n_retry, n_bytes} = '0;
			if (hit) begin
				n_match++;
				seen_sh = 1'b1;
				if (alloc_txn_in.is_retry)
					n_retry++;
				if (alloc_txn_in.is_sector)
					n_sector++;
				else
					n_chunk++;
				n_bytes += alloc_txn_in.is_sector ? perf_alloc_pkg::SECTOR_BYTES : perf_alloc_pkg::CHUNK_BYTES;
			end
			if (reg_wr_in && reg_addr_in == perf_alloc_pkg::OFS_STATUS && reg_wdata_in[0] && !hit)
				seen_sh = 1'b0;
			if (reg_wr_in && reg_addr_in == perf_alloc_pkg::OFS_MASK)
				mask_sh = reg_wdata_in[15:0];
			if (reg_wr_in && reg_addr_in == perf_alloc_pkg::OFS_CTRL)
				en_sh = reg_wdata_in[0];
		end
	end

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		report_and_stop();
	end

	initial begin
		failures     = 0;
		cmp_count    = 0;
		rst_in       = 1'b1;
		slow_in      = 1'b0;
		reg_addr_in  = 8'h00;
		reg_wdata_in = 32'h0;
		reg_wr_in    = 1'b0;
		reg_rd_in    = 1'b0;
		mask_sh      = 16'h0;
		{en_sh, seen_sh, exp_p, exp_s} = 4'h0;
		{n_match, n_sector, n_chunk, n_retry, n_bytes} = '0;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		reg_read(perf_alloc_pkg::OFS_MASK, 32'h0, "mask_reset");
		reg_read(perf_alloc_pkg::OFS_CTRL, 32'h0, "ctrl_reset");
		check_counts();
		reg_write(perf_alloc_pkg::OFS_MASK, 32'hffff_ffff);
		reg_write(8'h20, 32'hffff_ffff);
		reg_read(perf_alloc_pkg::OFS_MASK, 32'h0000_ffff, "mask_width");
		reg_read(8'h20, 32'h0, "unmapped");
		// counting is off after reset: this pass must leave everything at zero
		send_all_and_drain(-1);
		reg_write(perf_alloc_pkg::OFS_CTRL, 32'h1);
		reg_read(perf_alloc_pkg::OFS_CTRL, 32'h1, "ctrl_enable");
		for (int i = 0; i < 8; i++) begin
			slow_in <= i[0];
			send_all_and_drain(i);
		end
		reg_write(perf_alloc_pkg::OFS_STATUS, 32'h1);
		reg_read(perf_alloc_pkg::OFS_STATUS, {30'h0, en_sh, 1'b0}, "status_clear");
		report_and_stop();
	end
endmodule : testbench
